// file: src/uart_fmt_pkg.sv
// Constants, types and decode helpers shared by the interrupt and line format block
`default_nettype none
package uart_fmt_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the host port
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 3;
	localparam logic [2:0]  OFS_IRQ_IDENT   = 3'h0;
	localparam logic [2:0]  OFS_FIFO_SETUP  = 3'h1;
	localparam logic [2:0]  OFS_LINE_FORMAT = 3'h2;
	localparam logic [2:0]  OFS_IRQ_STATUS  = 3'h3;
	localparam logic [2:0]  OFS_IRQ_MASK    = 3'h4;

	// ----------------------------------------------------------------
	// Interrupt sources, sticky bit positions in priority order
	// ----------------------------------------------------------------
	localparam int          SRC_COUNT   = 5;
	localparam logic [2:0]  SRC_LINE    = 3'h0;
	localparam logic [2:0]  SRC_RXDATA  = 3'h1;
	localparam logic [2:0]  SRC_TIMEOUT = 3'h2;
	localparam logic [2:0]  SRC_THR     = 3'h3;
	localparam logic [2:0]  SRC_MODEM   = 3'h4;

	// Identification codes, bits 3:0
	localparam logic [3:0]  CODE_LINE    = 4'h6;
	localparam logic [3:0]  CODE_RXDATA  = 4'h4;
	localparam logic [3:0]  CODE_TIMEOUT = 4'hC;
	localparam logic [3:0]  CODE_THR     = 4'h2;
	localparam logic [3:0]  CODE_MODEM   = 4'h0;
	localparam logic [3:0]  CODE_NONE    = 4'h1;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          LF_DLAB_BIT       = 7;
	localparam int          LF_BREAK_BIT      = 6;
	localparam int          LF_PAR_MSB        = 5;
	localparam int          LF_PAR_LSB        = 3;
	localparam int          LF_STOP_BIT       = 2;
	localparam int          LF_LEN_MSB        = 1;
	localparam int          LF_LEN_LSB        = 0;
	localparam int          FS_ENABLE_BIT     = 0;
	localparam int          FS_TRIG_MSB       = 7;
	localparam int          FS_TRIG_LSB       = 6;
	localparam logic [7:0]  LINE_FORMAT_RESET = 8'h00;
	localparam logic [4:0]  IRQ_MASK_RESET    = 5'h00;
	localparam logic [4:0]  IRQ_STATUS_RESET  = 5'h00;
	localparam logic [1:0]  TRIG_SEL_RESET    = 2'h0;
	localparam logic [7:0]  RDATA_UNMAPPED    = 8'h00;

	// Receive trigger levels, in characters
	localparam int          FILL_W  = 5;
	localparam logic [4:0]  TRIG_01 = 5'h01;
	localparam logic [4:0]  TRIG_04 = 5'h04;
	localparam logic [4:0]  TRIG_08 = 5'h08;
	localparam logic [4:0]  TRIG_14 = 5'h0E;

	// Stop length in half bit times
	localparam logic [2:0]  STOP_ONE      = 3'h2;
	localparam logic [2:0]  STOP_ONE_HALF = 3'h3;
	localparam logic [2:0]  STOP_TWO      = 3'h4;

	// Character length base: code 00 means five bits
	localparam logic [3:0]  WORD_BASE = 4'h5;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PARITY_NONE   = 3'h0,
		PARITY_ODD    = 3'h1,
		PARITY_EVEN   = 3'h2,
		PARITY_FORCE1 = 3'h3,
		PARITY_FORCE0 = 3'h4
	} parity_e;

	// Gray along idle -> held -> idle
	typedef enum logic [0:0] {
		REPORT_IDLE = 1'b0,
		REPORT_HELD = 1'b1
	} report_e;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] source_code(input logic [2:0] idx);
		logic [3:0] code;
		code = CODE_MODEM;
		case (idx)
			SRC_LINE:    code = CODE_LINE;
			SRC_RXDATA:  code = CODE_RXDATA;
			SRC_TIMEOUT: code = CODE_TIMEOUT;
			SRC_THR:     code = CODE_THR;
			default:     code = CODE_MODEM;
		endcase
		return code;
	endfunction

	function automatic logic [4:0] trigger_level(input logic [1:0] sel);
		logic [4:0] lvl;
		lvl = TRIG_01;
		case (sel)
			2'h0:    lvl = TRIG_01;
			2'h1:    lvl = TRIG_04;
			2'h2:    lvl = TRIG_08;
			default: lvl = TRIG_14;
		endcase
		return lvl;
	endfunction

endpackage
`default_nettype wire

// file: src/irq_sticky.sv
// Sticky event flags, set by hardware, cleared by writing ones
`timescale 1ns/100ps
`default_nettype none

module irq_sticky #(
	parameter int N = 5
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] set_evt,
	input  wire logic         clr_wr,
	input  wire logic [N-1:0] clr_bits,
	output logic      [N-1:0] flags
);

	typedef struct packed {
		logic [N-1:0] flags;
	} sticky_s;

	sticky_s state_reg;
	sticky_s state_next;

	// Set beats clear so an event in the clearing cycle survives
	always_comb
	begin
		state_next = state_reg;
		if (clr_wr)
			state_next.flags = state_reg.flags & ~clr_bits;
		state_next.flags = state_next.flags | set_evt;
	end

	// Register
	always_ff @(posedge clk)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign flags = state_reg.flags;

endmodule

`default_nettype wire

// file: src/irq_rank.sv
// Picks the highest-priority pending source and its identification code
`timescale 1ns/100ps
`default_nettype none

module irq_rank #(
	parameter int N = 5
) (
	input  wire logic [N-1:0] pending,
	output logic              any,
	output logic [2:0]        idx,
	output logic [3:0]        code
);

	// Lowest index is the highest priority, so scan from the top down
	always_comb
	begin
		any  = 1'b0;
		idx  = 3'h0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (pending[i])
			begin
				any = 1'b1;
				idx = i[2:0];
			end
		end
		code = any ? uart_fmt_pkg::source_code(idx) : uart_fmt_pkg::CODE_NONE;
	end

endmodule

`default_nettype wire

// file: src/uart_irq_line_format.sv
// Interrupt identification and line format control for one serial channel
// Functional notes
// - Pending sources are ranked in four levels and the identification read gives the top one; the code ranks all five apart, data ready above timeout.
// - Once a source is reported no other is reported until it is serviced; host re-reads after.
// - Line status reports code 0110 at level 1 and received data ready reports 0100 at level 2.
// - Receive timeout reports 1100 at level 2, holding empty 0010 at level 3, modem 0000 at 4.
// - Identification bits 3:1 name the source for levels 1 to 3 and are zero by default.
// - Identification bit 0 is low while an interrupt is pending and high otherwise, high at reset.
// - Identification bits 7:6 are both one with FIFOs enabled and both zero otherwise, zero at reset.
// - Line format bit 7 selects divisor latch access when set and is clear after reset.
// - Line format bit 6 holds the serial output low for a break until software clears it.
// - Line format bits 5:3 pick no parity, odd, even, forced one or forced zero.
// - Line format bit 2 gives one stop bit, or one and a half for 5-bit and two for longer words.
// - Line format bits 1:0 choose 5, 6, 7 or 8 data bits and reset to 00.
// - The FIFO enable bit turns both FIFOs on, which is the mode bits 7:6 report.
// - In FIFO mode data ready is raised when the receive fill count equals the trigger level.
`timescale 1ns/100ps
`default_nettype none

module uart_irq_line_format #(
	parameter int FILL_W = uart_fmt_pkg::FILL_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	// Host register port
	input  wire logic [2:0]        addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [7:0]        rdata,
	// Interrupt source conditions from the rest of the channel
	input  wire logic              receiver_line_condition,
	input  wire logic              receive_data_available,
	input  wire logic [FILL_W-1:0] rx_fill_count,
	input  wire logic              rx_timeout,
	input  wire logic              transmit_holding_empty,
	input  wire logic              modem_line_change,
	// Serial path through the break gate
	input  wire logic              tx_serial_in,
	output logic                   tx_serial_out,
	// Format, mode and interrupt outputs
	output logic                   divisor_latch_access,
	output logic                   fifo_enable,
	output logic      [3:0]        data_bits,
	output logic      [2:0]        stop_half_bits,
	output logic      [2:0]        parity_mode,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]           line_format;
		logic                 fifo_en;
		logic [1:0]           trig_sel;
		logic [4:0]           irq_mask;
		uart_fmt_pkg::report_e report;
		logic [2:0]           held_idx;
		logic [7:0]           rdata;
		logic                 irq;
		logic                 tx_out;
		logic [3:0]           data_bits;
		logic [2:0]           stop_half;
		logic [2:0]           parity;
	} ctrl_s;

	ctrl_s state_reg;
	ctrl_s state_next;

	logic [4:0] src_set;
	logic [4:0] flags;
	logic [4:0] pending;
	logic       rank_any;
	logic [2:0] rank_idx;
	logic [3:0] rank_code;
	logic       held_live;
	logic [3:0] ident_code;
	logic [7:0] ident_byte;
	logic       rx_level_hit;
	logic       status_clr;

	// ----------------------------------------------------------------
	// Interrupt sources
	// ----------------------------------------------------------------

	// FIFO mode raises data ready on the fill count matching the trigger
	// Equality only: a fill count that jumps past the level raises nothing
	always_comb
	begin
		rx_level_hit = (rx_fill_count
			== FILL_W'(uart_fmt_pkg::trigger_level(state_reg.trig_sel)));
	end

	// Source conditions feed the sticky status bits
	always_comb
	begin
		src_set                            = '0;
		src_set[uart_fmt_pkg::SRC_LINE]    = receiver_line_condition;
		src_set[uart_fmt_pkg::SRC_RXDATA]  = state_reg.fifo_en ? rx_level_hit
			: receive_data_available;
		src_set[uart_fmt_pkg::SRC_TIMEOUT] = rx_timeout;
		src_set[uart_fmt_pkg::SRC_THR]     = transmit_holding_empty;
		src_set[uart_fmt_pkg::SRC_MODEM]   = modem_line_change;
	end

	// Status clear strobe, decoded once for the sticky flags
	assign status_clr = wr && (addr == uart_fmt_pkg::OFS_IRQ_STATUS);

	// Write one to clear; an event in the same cycle keeps its bit set
	irq_sticky #(
		.N (uart_fmt_pkg::SRC_COUNT)
	) u_sticky (
		.clk      (clk),
		.rst      (rst),
		.set_evt  (src_set),
		.clr_wr   (status_clr),
		.clr_bits (wdata[4:0]),
		.flags    (flags)
	);

	// Only unmasked sources compete for the report
	// Mask resets to zero, so nothing interrupts until software opts in
	assign pending = flags & state_reg.irq_mask;

	irq_rank #(
		.N (uart_fmt_pkg::SRC_COUNT)
	) u_rank (
		.pending (pending),
		.any     (rank_any),
		.idx     (rank_idx),
		.code    (rank_code)
	);

	// ----------------------------------------------------------------
	// Reported interrupt
	// ----------------------------------------------------------------

	// A held source stays reported while its flag is still pending
	// Masking a held source releases it just as a clear would
	assign held_live = pending[state_reg.held_idx];

	// Held code wins even if a higher source arrives meanwhile
	always_comb
	begin
		case (state_reg.report)
			uart_fmt_pkg::REPORT_HELD:
				ident_code = uart_fmt_pkg::source_code(state_reg.held_idx);
			uart_fmt_pkg::REPORT_IDLE:
				ident_code = uart_fmt_pkg::CODE_NONE;
			default:
				ident_code = uart_fmt_pkg::CODE_NONE;
		endcase
	end

	// Bits 7:6 mirror FIFO mode, bits 5:4 stay zero
	always_comb
	begin
		ident_byte = {{2{state_reg.fifo_en}}, 2'b00, ident_code};
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;

		// Report hold: a new pick only once the old one is serviced
		case (state_reg.report)
			uart_fmt_pkg::REPORT_IDLE:
			begin
				if (rank_any)
				begin
					state_next.report   = uart_fmt_pkg::REPORT_HELD;
					state_next.held_idx = rank_idx;
				end
			end
			uart_fmt_pkg::REPORT_HELD:
			begin
				if (!held_live)
				begin
					// Serviced; rank again so the next source is seen at once
					state_next.report   = rank_any ? uart_fmt_pkg::REPORT_HELD
						: uart_fmt_pkg::REPORT_IDLE;
					state_next.held_idx = rank_idx;
				end
			end
			default:
			begin
				state_next.report = uart_fmt_pkg::REPORT_IDLE;
			end
		endcase

		// Register writes; identification offset has no write effect
		if (wr)
		begin
			case (addr)
				uart_fmt_pkg::OFS_LINE_FORMAT:
					state_next.line_format = wdata;
				uart_fmt_pkg::OFS_FIFO_SETUP:
				begin
					state_next.fifo_en = wdata[uart_fmt_pkg::FS_ENABLE_BIT];
					// Other fields only take while the enable bit is written as one
					if (wdata[uart_fmt_pkg::FS_ENABLE_BIT])
						state_next.trig_sel = wdata[uart_fmt_pkg::FS_TRIG_MSB:
							uart_fmt_pkg::FS_TRIG_LSB];
				end
				uart_fmt_pkg::OFS_IRQ_MASK:
					state_next.irq_mask = wdata[4:0];
				default:
					state_next.irq_mask = state_reg.irq_mask;
			endcase
		end

		// Read data stands only in the cycle after the strobe
		state_next.rdata = uart_fmt_pkg::RDATA_UNMAPPED;
		if (rd)
		begin
			case (addr)
				uart_fmt_pkg::OFS_IRQ_IDENT:   state_next.rdata = ident_byte;
				uart_fmt_pkg::OFS_FIFO_SETUP:
					state_next.rdata = {state_reg.trig_sel, 5'h00, state_reg.fifo_en};
				uart_fmt_pkg::OFS_LINE_FORMAT: state_next.rdata = state_reg.line_format;
				uart_fmt_pkg::OFS_IRQ_STATUS:  state_next.rdata = {3'h0, flags};
				uart_fmt_pkg::OFS_IRQ_MASK:    state_next.rdata = {3'h0, state_reg.irq_mask};
				default:                       state_next.rdata = uart_fmt_pkg::RDATA_UNMAPPED;
			endcase
		end

		// Level interrupt while any unmasked flag is set
		state_next.irq = |pending;

		// Break forces the line low for as long as the bit stays set
		state_next.tx_out = state_reg.line_format[uart_fmt_pkg::LF_BREAK_BIT] ? 1'b0
			: tx_serial_in;

		// Word length: base five plus the two-bit code
		state_next.data_bits = uart_fmt_pkg::WORD_BASE
			+ {2'b00, state_reg.line_format[uart_fmt_pkg::LF_LEN_MSB:
				uart_fmt_pkg::LF_LEN_LSB]};

		// Stop length depends on the stop bit and on five-bit words
		if (!state_reg.line_format[uart_fmt_pkg::LF_STOP_BIT])
			state_next.stop_half = uart_fmt_pkg::STOP_ONE;
		else if (state_reg.line_format[uart_fmt_pkg::LF_LEN_MSB:
			uart_fmt_pkg::LF_LEN_LSB] == 2'b00)
			state_next.stop_half = uart_fmt_pkg::STOP_ONE_HALF;
		else
			state_next.stop_half = uart_fmt_pkg::STOP_TWO;

		// Parity: 001 odd, 011 even, 101 forced one, 111 forced zero
		// 001 stays odd, so forced one moves to 101 to keep the codes apart
		case (state_reg.line_format[uart_fmt_pkg::LF_PAR_MSB:uart_fmt_pkg::LF_PAR_LSB])
			3'b001:  state_next.parity = uart_fmt_pkg::PARITY_ODD;
			3'b011:  state_next.parity = uart_fmt_pkg::PARITY_EVEN;
			3'b101:  state_next.parity = uart_fmt_pkg::PARITY_FORCE1;
			3'b111:  state_next.parity = uart_fmt_pkg::PARITY_FORCE0;
			default: state_next.parity = uart_fmt_pkg::PARITY_NONE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	// Reset values give five bits, one stop, no parity, idle line high
	// Synchronous reset; only constants are loaded here
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg             <= '0;
			state_reg.line_format <= uart_fmt_pkg::LINE_FORMAT_RESET;
			state_reg.trig_sel    <= uart_fmt_pkg::TRIG_SEL_RESET;
			state_reg.irq_mask    <= uart_fmt_pkg::IRQ_MASK_RESET;
			state_reg.report      <= uart_fmt_pkg::REPORT_IDLE;
			state_reg.rdata       <= uart_fmt_pkg::RDATA_UNMAPPED;
			state_reg.tx_out      <= 1'b1;
			state_reg.data_bits   <= uart_fmt_pkg::WORD_BASE;
			state_reg.stop_half   <= uart_fmt_pkg::STOP_ONE;
			state_reg.parity      <= uart_fmt_pkg::PARITY_NONE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state register
	// ----------------------------------------------------------------
	assign rdata                = state_reg.rdata;
	assign irq                  = state_reg.irq;
	assign tx_serial_out        = state_reg.tx_out;
	assign divisor_latch_access = state_reg.line_format[uart_fmt_pkg::LF_DLAB_BIT];
	assign fifo_enable          = state_reg.fifo_en;
	assign data_bits            = state_reg.data_bits;
	assign stop_half_bits       = state_reg.stop_half;
	assign parity_mode          = state_reg.parity;

endmodule

`default_nettype wire

// file: verification/host_bus.sv
// Host processor model issuing register cycles on the parallel port
`timescale 1ns/100ps
`default_nettype none

module host_bus (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output var  logic [2:0] addr,
	output var  logic [7:0] wdata,
	output var  logic       wr,
	output var  logic       rd
);
	// Idle bus from time zero
	initial
	begin
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// One-cycle write; waits an edge first so strobes never double up
	task automatic put(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// One-cycle read; data stands only in the following cycle
	task automatic get(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	// Clear a serviced source, then look again for a lower one
	task automatic service(input logic [4:0] b, output logic [7:0] id);
		put(uart_fmt_pkg::OFS_IRQ_STATUS, {3'h0, b});
		repeat (2) @(posedge clk);
		get(uart_fmt_pkg::OFS_IRQ_IDENT, id);
	endtask
endmodule
`default_nettype wire

// file: verification/uart_irq_line_format_properties.sv
// Concurrent checks on the ports of the line format block
`timescale 1ns/100ps
`default_nettype none

module lf_props #(
	parameter int FILL_W = 5
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [2:0]        addr,
	input wire logic [7:0]        wdata,
	input wire logic              wr,
	input wire logic              rd,
	input wire logic [7:0]        rdata,
	input wire logic              receiver_line_condition,
	input wire logic              receive_data_available,
	input wire logic [FILL_W-1:0] rx_fill_count,
	input wire logic              rx_timeout,
	input wire logic              transmit_holding_empty,
	input wire logic              modem_line_change,
	input wire logic              tx_serial_in,
	input wire logic              tx_serial_out,
	input wire logic              divisor_latch_access,
	input wire logic              fifo_enable,
	input wire logic [3:0]        data_bits,
	input wire logic [2:0]        stop_half_bits,
	input wire logic [2:0]        parity_mode,
	input wire logic              irq
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Parity code per field value; 001 read as odd, 101 as forced one
	localparam logic [2:0] PAR_MAP [8] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h3, 3'h0, 3'h4};
	logic lf_w;
	logic cause;
	// Anything that may legally raise the interrupt two cycles on
	assign lf_w = wr && addr == uart_fmt_pkg::OFS_LINE_FORMAT;
	assign cause = receiver_line_condition | receive_data_available | rx_timeout
		| transmit_holding_empty | modem_line_change | (rx_fill_count != '0)
		| (wr && addr == uart_fmt_pkg::OFS_IRQ_MASK);

	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	// Break set, then three cycles with no format write
	sequence brk_set;
		lf_w && wdata[6] ##1 !lf_w [*3];
	endsequence

	// Identification read with no FIFO setup write in its cycle or the two cycles before it
	sequence id_rd_quiet;
		(!(wr && addr == uart_fmt_pkg::OFS_FIFO_SETUP)) [*3]
		##0 (rd && addr == uart_fmt_pkg::OFS_IRQ_IDENT);
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RESET_STATE:
		assert property ($past(rst) |-> !irq && tx_serial_out && !divisor_latch_access
			&& data_bits == 4'h5 && stop_half_bits == 3'h2 && parity_mode == 3'h0)
			else $error("outputs not at reset values");
	AST_WORD_LEN:
		assert property (lf_w |-> ##2 data_bits == 4'h5 + $past(wdata[1:0], 2))
			else $error("word length wrong");
	AST_STOP_LEN:
		assert property (lf_w |-> ##2 stop_half_bits == (!$past(wdata[2], 2) ? 3'h2
			: ($past(wdata[1:0], 2) == 2'h0 ? 3'h3 : 3'h4)))
			else $error("stop length wrong");
	AST_PARITY:
		assert property (lf_w |-> ##2 parity_mode == PAR_MAP[$past(wdata[5:3], 2)])
			else $error("parity mode wrong");
	AST_DIV_LATCH:
		assert property (lf_w |-> ##2 divisor_latch_access == $past(wdata[7], 2))
			else $error("divisor latch access wrong");
	AST_BREAK_HOLD:
		assert property (brk_set |-> !tx_serial_out && !$past(tx_serial_out))
			else $error("break not held low");
	AST_TX_PASS:
		assert property (lf_w && !wdata[6] ##1 !lf_w |-> ##1 tx_serial_out == $past(tx_serial_in))
			else $error("serial data not passed");
	AST_IDENT_SHAPE:
		assert property (rd && addr == uart_fmt_pkg::OFS_IRQ_IDENT |=> rdata[5:4] == 2'h0
			&& rdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hC})
			else $error("identification byte malformed");
	AST_FIFO_BITS:
		assert property (id_rd_quiet |=> rdata[7:6] == {2{fifo_enable}})
			else $error("mode bits disagree with fifo enable");
	AST_IRQ_CAUSE:
		assert property ($rose(irq) |-> $past(cause, 2))
			else $error("interrupt rose without cause");
endmodule

bind uart_irq_line_format lf_props #(.FILL_W(FILL_W)) lf_props_inst (
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.receiver_line_condition(receiver_line_condition),
	.receive_data_available(receive_data_available), .rx_fill_count(rx_fill_count),
	.rx_timeout(rx_timeout), .transmit_holding_empty(transmit_holding_empty),
	.modem_line_change(modem_line_change), .tx_serial_in(tx_serial_in),
	.tx_serial_out(tx_serial_out), .divisor_latch_access(divisor_latch_access),
	.fifo_enable(fifo_enable), .data_bits(data_bits), .stop_half_bits(stop_half_bits),
	.parity_mode(parity_mode), .irq(irq)
);
`default_nettype wire

// file: verification/uart_irq_line_format_tb_top.sv
// Self-checking bench for the interrupt identification and line format block
`timescale 1ns/100ps
`default_nettype none

module uart_irq_line_format_tb_top;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [4:0] src = 5'h00;
	logic [4:0] fill = 5'h00;
	logic       tx_in = 1'b1;
	logic       tx_prev = 1'b1;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v;
	logic       wr, rd, tx_out, dla, fen, irq;
	logic [3:0] dbits;
	logic [2:0] stop, par;
	int         n_mismatch = 0;
	int         compares = 0;
	integer     seed = 32'hE1F4;

	// Clock and random serial data into the break gate
	always #2.5 clk = ~clk;
	always @(posedge clk) tx_in <= 1'($random(seed));
	// Last serial bit the gate saw, for the pass-through check
	always @(posedge clk) tx_prev <= tx_in;

	uart_irq_line_format uart_irq_line_format_inst (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.receiver_line_condition(src[0]), .receive_data_available(src[1]),
		.rx_fill_count(fill), .rx_timeout(src[2]), .transmit_holding_empty(src[3]),
		.modem_line_change(src[4]), .tx_serial_in(tx_in), .tx_serial_out(tx_out),
		.divisor_latch_access(dla), .fifo_enable(fen), .data_bits(dbits),
		.stop_half_bits(stop), .parity_mode(par), .irq(irq)
	);

	host_bus host_bus_inst (
		.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
	);

	// Compare, count, report
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_bus_inst.get(a, d);
		chk(d, exp);
	endtask

	task automatic schk(input logic [4:0] b, input logic [7:0] exp);
		host_bus_inst.service(b, v);
		chk(v, exp);
	endtask

	// One-cycle source pulse, then time for flag and report to settle
	task automatic pulse(input logic [4:0] s);
		src <= s;
		@(posedge clk);
		src <= 5'h00;
		repeat (4) @(posedge clk);
	endtask

	// Identification byte per source index, FIFOs off
	function automatic logic [7:0] code_of(input int i);
		logic [3:0] t [5] = '{4'h6, 4'h4, 4'hC, 4'h2, 4'h0};
		return {4'h0, t[i]};
	endfunction

	// Expected {stop length, parity mode} for a line format byte
	function automatic logic [7:0] fmt_of(input logic [7:0] f);
		logic [2:0] s;
		logic [2:0] p;
		s = !f[2] ? 3'h2 : (f[1:0] == 2'h0 ? 3'h3 : 3'h4);
		p = f[3] ? 3'({1'b0, f[5:4]} + 3'h1) : 3'h0;
		return {2'h0, s, p};
	endfunction

	// Receive trigger level per select code
	function automatic logic [4:0] trig_of(input int s);
		logic [4:0] t [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
		return t[s];
	endfunction

	task automatic wrap_up();
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	initial
	begin
		#100000;
		n_mismatch++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h01);
		rchk(uart_fmt_pkg::OFS_LINE_FORMAT, 8'h00);
		// Every parity, stop and length field, random upper bits
		for (int i = 0; i < 64; i++)
		begin
			v = {2'($random(seed)), 6'(i)};
			host_bus_inst.put(uart_fmt_pkg::OFS_LINE_FORMAT, v);
			rchk(uart_fmt_pkg::OFS_LINE_FORMAT, v);
			chk({dla, 3'h0, dbits}, {v[7], 3'h0, 4'h5 + {2'h0, v[1:0]}});
			chk({2'h0, stop, par}, fmt_of(v));
			chk({7'h0, tx_out}, {7'h0, tx_prev & ~v[6]});
		end
		// Reset in mid-run must restore the default format
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rchk(uart_fmt_pkg::OFS_LINE_FORMAT, 8'h00);
		chk({4'h0, dbits}, 8'h05);
		// Each source alone, unmasked
		host_bus_inst.put(uart_fmt_pkg::OFS_IRQ_MASK, 8'h1F);
		for (int i = 0; i < 5; i++)
		begin
			pulse(5'h01 << i);
			chk({7'h0, irq}, 8'h01);
			rchk(uart_fmt_pkg::OFS_IRQ_IDENT, code_of(i));
			schk(5'h01 << i, 8'h01);
		end
		// Ranking, and a held report not displaced by a higher arrival
		pulse(5'h18);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h02);
		pulse(5'h01);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h02);
		schk(5'h08, 8'h06);
		schk(5'h01, 8'h00);
		schk(5'h10, 8'h01);
		pulse(5'h06);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h04);
		schk(5'h02, 8'h0C);
		schk(5'h04, 8'h01);
		// Masked source stays sticky but silent until unmasked
		host_bus_inst.put(uart_fmt_pkg::OFS_IRQ_MASK, 8'h00);
		pulse(5'h01);
		chk({7'h0, irq}, 8'h00);
		rchk(uart_fmt_pkg::OFS_IRQ_STATUS, 8'h01);
		host_bus_inst.put(uart_fmt_pkg::OFS_IRQ_MASK, 8'h01);
		pulse(5'h00);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h06);
		chk({7'h0, irq}, 8'h01);
		schk(5'h01, 8'h01);
		chk({7'h0, irq}, 8'h00);
		// FIFO mode, trigger of four: three is quiet, four raises
		host_bus_inst.put(uart_fmt_pkg::OFS_IRQ_MASK, 8'h1F);
		host_bus_inst.put(uart_fmt_pkg::OFS_FIFO_SETUP, 8'h41);
		fill <= 5'h03;
		pulse(5'h00);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'hC1);
		chk({7'h0, fen}, 8'h01);
		fill <= 5'h04;
		pulse(5'h00);
		fill <= 5'h00;
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'hC4);
		schk(5'h02, 8'hC1);
		// Every trigger select; data ready pin is ignored in FIFO mode
		for (int s = 0; s < 4; s++)
		begin
			host_bus_inst.put(uart_fmt_pkg::OFS_FIFO_SETUP, {2'(s), 6'h01});
			fill <= trig_of(s) - 5'h01;
			pulse(5'h02);
			rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'hC1);
			fill <= trig_of(s);
			pulse(5'h00);
			fill <= 5'h00;
			rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'hC4);
			schk(5'h02, 8'hC1);
		end
		host_bus_inst.put(uart_fmt_pkg::OFS_FIFO_SETUP, 8'h00);
		rchk(uart_fmt_pkg::OFS_FIFO_SETUP, 8'hC0);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h01);
		// Identification is read-only; unmapped places read zero
		host_bus_inst.put(uart_fmt_pkg::OFS_IRQ_IDENT, 8'hFF);
		rchk(uart_fmt_pkg::OFS_IRQ_IDENT, 8'h01);
		for (int a = 5; a < 8; a++)
			rchk(3'(a), 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
